// ### src/vp_pkg.sv
// proving sequencer package: schedules, states, timing counts, carriers
// assumes a single 125 MHz reference clock
package vp_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned OPEN_TIME_S = 4;
  localparam int unsigned SETTLE_TIME_S = 3;
  localparam int unsigned COMMIT_HOLD_S = 5;
  localparam int unsigned MIN_TEST_S = 10;
  localparam int unsigned MAX_TEST_S = 3600;
  localparam int unsigned DEFAULT_TEST_S = 30;
  localparam int unsigned SEC_CYCLES = CLK_HZ;
  // test time grid: fine steps up to one minute, then coarser
  localparam int unsigned FINE_STEP_MAX_S = 60;
  localparam int unsigned MID_STEP_MAX_S = 600;
  localparam int unsigned MID_STEP_S = 10;
  localparam int unsigned COARSE_STEP_S = 60;
  localparam int unsigned TIME_W = 12;
  localparam logic [TIME_W-1:0] TEST_RESET_S = TIME_W'(DEFAULT_TEST_S);

  typedef enum logic [2:0] {
    SCHED_NEVER = 3'b000,
    SCHED_BEFORE = 3'b001,
    SCHED_AFTER = 3'b010,
    SCHED_BOTH = 3'b011,
    SCHED_SPLIT = 3'b100
  } sched_t;
  localparam sched_t SCHED_RESET = SCHED_NEVER;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LP_OPEN = 3'b001,
    ST_LP_SETTLE = 3'b010,
    ST_LP_TEST = 3'b011,
    ST_HP_OPEN = 3'b100,
    ST_HP_SETTLE = 3'b101,
    ST_HP_TEST = 3'b110,
    ST_FAIL = 3'b111
  } vp_state_t;

  // proving configuration as staged and as committed
  typedef struct packed {
    sched_t sched;
    logic [TIME_W-1:0] test_s;
  } vp_cfg_t;

  // valve commands driven during proving
  typedef struct packed {
    logic upstream;
    logic downstream;
  } valve_cmd_t;
endpackage

// ### src/vp_sec_timer.sv
// second-resolution interval timer for the proving sequence
// assumes a one-cycle load pulse; counts whole seconds from REF_CLK
`timescale 1ns/1ps
`default_nettype none
module vp_sec_timer
#(
  parameter int unsigned SEC_CYC = 125_000_000,
  parameter int unsigned W = 12
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] secs,
  output logic done
);
  initial
  begin
    if (SEC_CYC < 2) $error("vp_sec_timer: SEC_CYC too small");
  end
  logic [31:0] tick_r;
  logic [W-1:0] left_r;
  logic run_r;
  wire tick_end = (tick_r == SEC_CYC - 1);
  assign done = run_r && (left_r == '0);
  // exact second count, well inside the ten percent tolerance
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_r <= '0;
      left_r <= '0;
      run_r <= 1'b0;
    end
    else if (load)
    begin
      tick_r <= '0;
      left_r <= secs;
      run_r <= 1'b1;
    end
    else if (run_r && left_r != '0)
    begin
      tick_r <= tick_end ? '0 : tick_r + 32'd1;
      if (tick_end)
        left_r <= left_r - W'(1);
    end
  end
endmodule
`default_nettype wire

// ### src/vp_hold_detect.sv
// reset button hold detector: pulses once after a continuous hold
// assumes the button input is already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module vp_hold_detect
#(
  parameter int unsigned HOLD_CYC = 625_000_000
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic btn,
  output logic held
);
  initial
  begin
    if (HOLD_CYC < 1) $error("vp_hold_detect: HOLD_CYC must be positive");
  end
  logic [31:0] cnt_r;
  logic fired_r;
  wire reached = (cnt_r == HOLD_CYC - 1);
  assign held = btn && reached && !fired_r;
  // any release restarts the hold
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      fired_r <= 1'b0;
    end
    else if (!btn)
    begin
      cnt_r <= '0;
      fired_r <= 1'b0;
    end
    else if (reached)
      fired_r <= 1'b1;
    else
      cnt_r <= cnt_r + 32'd1;
  end
endmodule
`default_nettype wire

// ### src/vp_sequencer.sv
// valve seat proving sequencer between burner programmer and field valves
// assumes programmer requests are on REF_CLK; field pins are asynchronous
// Operation
// RULE_01 - five schedules held; never means no proving at all
// RULE_02 - before schedule proves after safe start check, before run
// RULE_03 - after schedule proves after run, before safety relay release
// RULE_04 - both schedule proves fully at before and after points
// RULE_05 - split: high pressure test before, low pressure test after
// RULE_06 - all proving intervals within ten percent
// RULE_07 - prove only while valve power input is present
// RULE_08 - low test: downstream open four seconds, upstream closed
// RULE_09 - ignore switch three seconds after downstream closes
// RULE_10 - switch active during low test time means lockout
// RULE_11 - high test: upstream open four seconds, downstream closed
// RULE_12 - ignore switch three seconds after upstream closes
// RULE_13 - switch inactive during high test time means lockout
// RULE_14 - test time steps 1 s, 10 s above 60, 60 s above 600
// RULE_15 - test times below ten seconds are refused
// RULE_16 - configuration changes accepted only in standby or lockout
// RULE_17 - settings committed after reset button held five seconds
// RULE_18 - low pressure test completes before high pressure test
`timescale 1ns/1ps
`default_nettype none
module vp_sequencer
  import vp_pkg::*;
#(
  parameter int unsigned SEC_CYC = vp_pkg::SEC_CYCLES,
  parameter int unsigned HOLD_CYC = vp_pkg::COMMIT_HOLD_S * vp_pkg::SEC_CYCLES
)
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic BEFORE_REQ,
  input wire logic AFTER_REQ,
  input wire logic IN_STANDBY,
  input wire logic IN_LOCKOUT,
  input wire logic CFG_WR,
  input wire vp_pkg::vp_cfg_t CFG_IN,
  input wire logic VALVE_POWER,
  input wire logic SEAL_PRESSURE_SWITCH,
  input wire logic RESET_BUTTON,
  output logic PROVE_DONE,
  output logic PROVE_BUSY,
  output logic LOCKOUT_REQ,
  output logic CFG_REJECT,
  output logic COMMIT_PULSE,
  output vp_pkg::valve_cmd_t VALVE_CMD,
  output vp_pkg::vp_cfg_t CFG_ACTIVE,
  output vp_pkg::vp_cfg_t CFG_STAGED
);
  import vp_pkg::*;

  initial
  begin
    if (SEC_CYC < 2) $error("vp_sequencer: SEC_CYC too small");
    if (HOLD_CYC < 1) $error("vp_sequencer: HOLD_CYC too small");
  end

  // legal test time: at least ten seconds, on the step grid
  function automatic logic time_ok(input logic [TIME_W-1:0] t);
    logic ok;
    ok = 1'b1;
    if (t < TIME_W'(MIN_TEST_S) || t > TIME_W'(MAX_TEST_S))
      ok = 1'b0;
    else if (t > TIME_W'(MID_STEP_MAX_S))
      ok = ((t % TIME_W'(COARSE_STEP_S)) == '0);
    else if (t > TIME_W'(FINE_STEP_MAX_S))
      ok = ((t % TIME_W'(MID_STEP_S)) == '0);
    return ok;
  endfunction

  // two-flop synchronisers for field pins
  logic [1:0] pwr_s_r, psw_s_r, btn_s_r;
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pwr_s_r <= 2'b00;
      psw_s_r <= 2'b00;
      btn_s_r <= 2'b00;
    end
    else
    begin
      pwr_s_r <= {pwr_s_r[0], VALVE_POWER};
      psw_s_r <= {psw_s_r[0], SEAL_PRESSURE_SWITCH};
      btn_s_r <= {btn_s_r[0], RESET_BUTTON};
    end
  end
  wire pwr = pwr_s_r[1];
  wire psw = psw_s_r[1];
  wire btn = btn_s_r[1];

  // configuration staging and commit
  vp_cfg_t staged_r, active_r;
  logic reject_r;
  wire cfg_window = IN_STANDBY || IN_LOCKOUT; // see RULE_16
  wire sched_ok = (CFG_IN.sched <= SCHED_SPLIT);
  wire cfg_good = cfg_window && sched_ok && time_ok(CFG_IN.test_s);
  wire commit;

  vp_hold_detect #(.HOLD_CYC(HOLD_CYC)) u_hold (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .btn(btn),
    .held(commit)
  );
  wire do_commit = commit && cfg_window; // see RULE_17

  // staged settings take legal writes only; commit copies them over
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      staged_r <= '{sched: SCHED_RESET, test_s: TEST_RESET_S};
      active_r <= '{sched: SCHED_RESET, test_s: TEST_RESET_S};
      reject_r <= 1'b0;
    end
    else
    begin
      reject_r <= CFG_WR && !cfg_good; // see RULE_15
      if (CFG_WR && cfg_good) // see RULE_14
        staged_r <= CFG_IN;
      if (do_commit)
        active_r <= staged_r; // see RULE_17
    end
  end

  // which tests run at each point
  wire sched_t s = active_r.sched;
  wire before_lp = (s == SCHED_BEFORE) || (s == SCHED_BOTH); // see RULE_02
  wire before_hp = before_lp || (s == SCHED_SPLIT); // see RULE_05
  wire after_lp = (s == SCHED_AFTER) || (s == SCHED_BOTH)
                  || (s == SCHED_SPLIT); // see RULE_03
  wire after_hp = (s == SCHED_AFTER) || (s == SCHED_BOTH); // see RULE_04

  // sequencer state
  vp_state_t state_r, state_nxt;
  logic hp_pending_r, hp_pending_nxt;
  logic done_r, done_nxt;
  logic lock_r, lock_nxt;
  logic load;
  logic [TIME_W-1:0] load_s;
  wire t_done;

  vp_sec_timer #(.SEC_CYC(SEC_CYC), .W(TIME_W)) u_timer (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .load(load),
    .secs(load_s),
    .done(t_done)
  );

  wire req = BEFORE_REQ || AFTER_REQ;
  wire want_lp = BEFORE_REQ ? before_lp : after_lp;
  wire want_hp = BEFORE_REQ ? before_hp : after_hp;
  wire in_test = (state_r != ST_IDLE) && (state_r != ST_FAIL);

  // next state; valve power loss aborts into lockout
  always_comb
  begin
    state_nxt = state_r;
    hp_pending_nxt = hp_pending_r;
    done_nxt = 1'b0;
    lock_nxt = lock_r;
    load = 1'b0;
    load_s = TIME_W'(OPEN_TIME_S);
    if (in_test && !pwr) // see RULE_07
    begin
      state_nxt = ST_FAIL;
      lock_nxt = 1'b1;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (req && (s == SCHED_NEVER)) // see RULE_01
            done_nxt = 1'b1;
          else if (req && pwr && want_lp) // see RULE_18
          begin
            state_nxt = ST_LP_OPEN;
            hp_pending_nxt = want_hp;
            load = 1'b1; // see RULE_08
          end
          else if (req && pwr && want_hp)
          begin
            state_nxt = ST_HP_OPEN;
            hp_pending_nxt = 1'b0;
            load = 1'b1; // see RULE_11
          end
          else if (req && pwr)
            done_nxt = 1'b1;
        end
        ST_LP_OPEN:
          if (t_done)
          begin
            state_nxt = ST_LP_SETTLE;
            load = 1'b1;
            load_s = TIME_W'(SETTLE_TIME_S); // see RULE_09
          end
        ST_LP_SETTLE:
          if (t_done)
          begin
            state_nxt = ST_LP_TEST;
            load = 1'b1;
            load_s = active_r.test_s; // see RULE_06
          end
        ST_LP_TEST:
          if (psw) // see RULE_10
          begin
            state_nxt = ST_FAIL;
            lock_nxt = 1'b1;
          end
          else if (t_done && hp_pending_r)
          begin
            state_nxt = ST_HP_OPEN;
            hp_pending_nxt = 1'b0;
            load = 1'b1;
          end
          else if (t_done)
          begin
            state_nxt = ST_IDLE;
            done_nxt = 1'b1;
          end
        ST_HP_OPEN:
          if (t_done)
          begin
            state_nxt = ST_HP_SETTLE;
            load = 1'b1;
            load_s = TIME_W'(SETTLE_TIME_S); // see RULE_12
          end
        ST_HP_SETTLE:
          if (t_done)
          begin
            state_nxt = ST_HP_TEST;
            load = 1'b1;
            load_s = active_r.test_s;
          end
        ST_HP_TEST:
          if (!psw) // see RULE_13
          begin
            state_nxt = ST_FAIL;
            lock_nxt = 1'b1;
          end
          else if (t_done)
          begin
            state_nxt = ST_IDLE;
            done_nxt = 1'b1;
          end
        ST_FAIL:
          if (do_commit || (IN_LOCKOUT && btn && !req))
          begin
            state_nxt = ST_IDLE;
            lock_nxt = 1'b0;
          end
      endcase
    end
  end

  // state registers
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_r <= ST_IDLE;
      hp_pending_r <= 1'b0;
      done_r <= 1'b0;
      lock_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      hp_pending_r <= hp_pending_nxt;
      done_r <= done_nxt;
      lock_r <= lock_nxt;
    end
  end

  // valve commands: one valve at a time, only in the open phases
  valve_cmd_t valve_r;
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      valve_r <= '0;
    else
    begin
      valve_r.downstream <= (state_nxt == ST_LP_OPEN); // see RULE_08
      valve_r.upstream <= (state_nxt == ST_HP_OPEN); // see RULE_11
    end
  end

  // outputs
  assign PROVE_DONE = done_r;
  assign PROVE_BUSY = in_test;
  assign LOCKOUT_REQ = lock_r;
  assign CFG_REJECT = reject_r;
  assign COMMIT_PULSE = do_commit;
  assign VALVE_CMD = valve_r;
  assign CFG_ACTIVE = active_r;
  assign CFG_STAGED = staged_r;
endmodule
`default_nettype wire

// ### tb/vp_sequencer_asserts.sv
// port checker for the proving sequencer, bound to every instance
// assumes SEC_CYC matches the sequencer's own setting
`timescale 1ns/1ps
`default_nettype none
module vp_sequencer_asserts
  import vp_pkg::*;
#(
  parameter int unsigned SEC_CYC = 10
)
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic IN_STANDBY,
  input wire logic IN_LOCKOUT,
  input wire logic CFG_WR,
  input wire vp_pkg::vp_cfg_t CFG_IN,
  input wire logic VALVE_POWER,
  input wire logic PROVE_BUSY,
  input wire logic LOCKOUT_REQ,
  input wire logic CFG_REJECT,
  input wire logic COMMIT_PULSE,
  input wire vp_pkg::valve_cmd_t VALVE_CMD,
  input wire vp_pkg::vp_cfg_t CFG_ACTIVE,
  input wire vp_pkg::vp_cfg_t CFG_STAGED
);
  localparam int unsigned LO = SEC_CYC * 36 / 10;
  localparam int unsigned HI = SEC_CYC * 44 / 10;
  logic [15:0] dn_r;
  logic [15:0] up_r;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // cycles each valve has stood open
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      dn_r <= 16'h0;
      up_r <= 16'h0;
    end
    else
    begin
      dn_r <= VALVE_CMD.downstream ? dn_r + 16'h1 : 16'h0;
      up_r <= VALVE_CMD.upstream ? up_r + 16'h1 : 16'h0;
    end
  end
  AST_ONE_OPEN: assert property (!(VALVE_CMD.upstream && VALVE_CMD.downstream))
    else $error("both valves open");
  AST_DN_TIME: assert property ($fell(VALVE_CMD.downstream) && !LOCKOUT_REQ
    |-> dn_r >= LO && dn_r <= HI) else $error("downstream open time");
  AST_UP_TIME: assert property ($fell(VALVE_CMD.upstream) && !LOCKOUT_REQ
    |-> up_r >= LO && up_r <= HI) else $error("upstream open time");
  AST_SETTLE: assert property (($fell(VALVE_CMD.downstream) ||
    $fell(VALVE_CMD.upstream)) && !LOCKOUT_REQ |-> !LOCKOUT_REQ [*8])
    else $error("switch not ignored while settling");
  AST_LOCK_SHUT: assert property (LOCKOUT_REQ |=> VALVE_CMD == 2'b00)
    else $error("valve open in lockout");
  AST_REJ_STATE: assert property (CFG_WR && !IN_STANDBY && !IN_LOCKOUT
    |=> CFG_REJECT) else $error("setting taken outside standby");
  AST_REJ_SHORT: assert property (CFG_WR && CFG_IN.test_s < 12'h00a
    |=> CFG_REJECT) else $error("short test time taken");
  AST_COMMIT: assert property (COMMIT_PULSE |-> IN_STANDBY || IN_LOCKOUT)
    else $error("commit outside standby");
  AST_COMMIT_COPY: assert property (COMMIT_PULSE
    |=> CFG_ACTIVE == $past(CFG_STAGED)) else $error("commit lost settings");
  AST_ACTIVE_HOLD: assert property (!COMMIT_PULSE
    |=> $stable(CFG_ACTIVE)) else $error("settings changed without commit");
  AST_POWER: assert property (!VALVE_POWER [*6] |-> VALVE_CMD == 2'b00)
    else $error("valve open without power");
  AST_NEVER: assert property (CFG_ACTIVE.sched == SCHED_NEVER && !PROVE_BUSY
    |=> !PROVE_BUSY) else $error("proving under never");
  COV_LOCK: cover property ($rose(LOCKOUT_REQ));
  COV_COMMIT: cover property (COMMIT_PULSE);
  COV_HP: cover property ($fell(VALVE_CMD.upstream));
endmodule
bind vp_sequencer vp_sequencer_asserts #(.SEC_CYC(SEC_CYC)) i_vp_sequencer_asserts
(
  .REF_CLK(REF_CLK),
  .RST_N(RST_N),
  .IN_STANDBY(IN_STANDBY),
  .IN_LOCKOUT(IN_LOCKOUT),
  .CFG_WR(CFG_WR),
  .CFG_IN(CFG_IN),
  .VALVE_POWER(VALVE_POWER),
  .PROVE_BUSY(PROVE_BUSY),
  .LOCKOUT_REQ(LOCKOUT_REQ),
  .CFG_REJECT(CFG_REJECT),
  .COMMIT_PULSE(COMMIT_PULSE),
  .VALVE_CMD(VALVE_CMD),
  .CFG_ACTIVE(CFG_ACTIVE),
  .CFG_STAGED(CFG_STAGED)
);
`default_nettype wire

// ### tb/vp_valve_model.sv
// field model: two series valves and the seal pressure switch
// assumes commands high = open; leaks chosen by the bench
`timescale 1ns/1ps
`default_nettype none
module vp_valve_model
  import vp_pkg::*;
(
  input wire logic clk,
  input wire vp_pkg::valve_cmd_t cmd,
  input wire logic leak_up,
  input wire logic leak_dn,
  output logic sw
);
  logic press_r = 1'b0;
  // trapped pressure follows the open valve, else a leaking seat
  always @(posedge clk)
  begin
    if (cmd.downstream)
      press_r <= 1'b0;
    else if (cmd.upstream || leak_up)
      press_r <= 1'b1;
    else if (leak_dn)
      press_r <= 1'b0;
  end
  assign sw = press_r;
endmodule
`default_nettype wire

// ### tb/vp_sequencer_tb.sv
// self-checking bench for the proving sequencer with a valve model
// assumes ten cycles per second and a fifty cycle commit hold
`timescale 1ns/1ps
`default_nettype none
module vp_sequencer_tb;
  import vp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic bef = 1'b0;
  logic aft = 1'b0;
  logic stby = 1'b1;
  logic lko = 1'b0;
  logic wr = 1'b0;
  vp_cfg_t cin = '0;
  logic pwr = 1'b1;
  logic btn = 1'b0;
  logic lk_up = 1'b0;
  logic lk_dn = 1'b0;
  logic done, busy, lock, rej, cmt, sw;
  valve_cmd_t vc;
  vp_cfg_t act, stg;
  int n_fail = 0;
  int n_compared = 0;
  always #4 clk = ~clk;
  vp_sequencer #(.SEC_CYC(10), .HOLD_CYC(50)) i_vp_sequencer
  (
    .REF_CLK(clk), .RST_N(rst_n), .BEFORE_REQ(bef), .AFTER_REQ(aft),
    .IN_STANDBY(stby), .IN_LOCKOUT(lko), .CFG_WR(wr), .CFG_IN(cin),
    .VALVE_POWER(pwr), .SEAL_PRESSURE_SWITCH(sw), .RESET_BUTTON(btn),
    .PROVE_DONE(done), .PROVE_BUSY(busy), .LOCKOUT_REQ(lock),
    .CFG_REJECT(rej), .COMMIT_PULSE(cmt), .VALVE_CMD(vc),
    .CFG_ACTIVE(act), .CFG_STAGED(stg)
  );
  vp_valve_model i_vp_valve_model
  (
    .clk(clk), .cmd(vc), .leak_up(lk_up), .leak_dn(lk_dn), .sw(sw)
  );
  task automatic stop_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one settings write; reports whether it was refused
  task automatic wcfg(input sched_t s, input logic [11:0] t, input logic r);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    cin <= '{sched: s, test_s: t};
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (3)
    begin
      #1 seen = seen | rej;
      @(posedge clk);
    end
    check(seen, r);
  endtask
  // hold the button: nothing commits early, exactly one commit after the hold
  task automatic setup(input sched_t s);
    vp_cfg_t old;
    int k;
    int nc;
    old = act;
    nc = 0;
    stby <= 1'b1;
    wcfg(s, 12'h00a, 1'b0);
    btn <= 1'b1;
    // sample mid-cycle so the combinational commit pulse is seen
    for (k = 0; k < 70; k++)
    begin
      @(posedge clk);
      #1;
      if (k == 29)
        check(act, old);
      nc = nc + cmt;
    end
    @(posedge clk);
    btn <= 1'b0;
    check(nc, 1);
    check(act, {s, 12'h00a});
    stby <= 1'b0;
  endtask
  // one proving point; watches valves until done or lockout
  task automatic run(input logic a, input logic lp, input logic hp,
    input logic lk);
    int n, td, tu, nd, nu, tc, nb;
    td = 0;
    tu = 0;
    nd = 0;
    nu = 0;
    tc = 0;
    nb = 0;
    @(posedge clk);
    if (a)
      aft <= 1'b1;
    else
      bef <= 1'b1;
    for (n = 1; n < 2000 && !done && !lock; n++)
    begin
      @(posedge clk);
      #1;
      if (vc.downstream && nd++ == 0)
        td = n;
      if (vc.upstream && nu++ == 0)
        tu = n;
      if (vc != 2'b00)
        tc = n;
      if (busy)
        nb++;
    end
    if (n >= 2000)
    begin
      n_fail++;
      stop_test();
    end
    bef <= 1'b0;
    aft <= 1'b0;
    check(nd > 0, lp);
    check(nu > 0, hp);
    check(lock, lk);
    check(nb > 0, lp || hp);
    if (lp)
      check(nd >= 36 && nd <= 44, 1'b1);
    if (hp)
      check(nu >= 36 && nu <= 44, 1'b1);
    if (lp && hp)
      check(td < tu, 1'b1);
    if (lk)
      check(n - tc >= 27, 1'b1);
    @(posedge clk);
  endtask
  task automatic t_never;
    run(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test never done");
  endtask
  task automatic t_config;
    stby <= 1'b0;
    wcfg(SCHED_BOTH, 12'h00a, 1'b1);
    check(stg, {SCHED_NEVER, 12'h01e});
    stby <= 1'b1;
    wcfg(SCHED_BOTH, 12'h009, 1'b1);
    wcfg(SCHED_BOTH, 12'h041, 1'b1);
    wcfg(SCHED_BOTH, 12'h046, 1'b0);
    wcfg(SCHED_BOTH, 12'h258, 1'b0);
    wcfg(SCHED_BOTH, 12'h26c, 1'b1);
    check(stg, {SCHED_BOTH, 12'h258});
    wcfg(SCHED_BOTH, 12'h294, 1'b0);
    $display("test config done");
  endtask
  task automatic t_sched;
    setup(SCHED_BOTH);
    run(1'b0, 1'b1, 1'b1, 1'b0);
    run(1'b1, 1'b1, 1'b1, 1'b0);
    setup(SCHED_SPLIT);
    run(1'b0, 1'b0, 1'b1, 1'b0);
    run(1'b1, 1'b1, 1'b0, 1'b0);
    $display("test schedules done");
  endtask
  // clear a lockout by a short press while the programmer is locked out
  task automatic unlock;
    int k;
    lko <= 1'b1;
    btn <= 1'b1;
    repeat (5) @(posedge clk);
    btn <= 1'b0;
    for (k = 0; k < 100 && lock; k++)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    check(lock, 1'b0);
    if (lock)
      stop_test();
    lko <= 1'b0;
    lk_up <= 1'b0;
    lk_dn <= 1'b0;
  endtask
  task automatic t_leak;
    setup(SCHED_BOTH);
    lk_up <= 1'b1;
    run(1'b0, 1'b1, 1'b0, 1'b1);
    unlock();
    lk_dn <= 1'b1;
    run(1'b0, 1'b1, 1'b1, 1'b1);
    unlock();
    $display("test leaks done");
  endtask
  task automatic t_power;
    pwr <= 1'b0;
    repeat (4) @(posedge clk);
    bef <= 1'b1;
    repeat (60) @(posedge clk);
    check(busy, 1'b0);
    check(vc, 2'b00);
    bef <= 1'b0;
    pwr <= 1'b1;
    repeat (4) @(posedge clk);
    // power lost while the downstream valve is open for the low test forces lockout
    bef <= 1'b1;
    repeat (12) @(posedge clk);
    check(busy, 1'b1);
    pwr <= 1'b0;
    repeat (6) @(posedge clk);
    check(lock, 1'b1);
    check(vc, 2'b00);
    bef <= 1'b0;
    unlock();
    pwr <= 1'b1;
    repeat (4) @(posedge clk);
    $display("test power done");
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check(act, {SCHED_NEVER, 12'h01e});
    check(stg, {SCHED_NEVER, 12'h01e});
    t_never();
    t_config();
    t_sched();
    t_leak();
    t_power();
    stop_test();
  end
endmodule
`default_nettype wire
